// [design/hppc_pkg.sv]
// Package: register map, fields and reset values of the host port pad control
package hppc_pkg;
    localparam int ADDR_W = 4;
    // Register offsets
    localparam logic [3:0] BANK_OFF = 4'h0;
    localparam logic [3:0] GPIO_OUT_OFF = 4'h1;
    localparam logic [3:0] GPIO_DIR_OFF = 4'h2;
    localparam logic [3:0] GPIO_IN_OFF = 4'h3;
    localparam logic [3:0] STATUS_OFF = 4'h4;
    localparam logic [3:0] CORE_DATA_OFF = 4'h5;
    // Bank switch control register fields; register and keeper reset values
    localparam int DKEEP_BIT = 0;
    localparam int HKEEP_BIT = 1;
    localparam logic [1:0] BANK_RST = 2'h0;
    localparam logic [7:0] GPIO_RST = 8'h00;
    localparam logic [15:0] KEEP_RST = 16'h0000;
    // Status register fields
    localparam int ST_WIDE_BIT = 0;
    localparam int ST_FLOAT_BIT = 1;
    localparam int ST_HOLD_BIT = 2;
    localparam int ST_RESET_BIT = 3;
endpackage

// [design/hppc_keeper.sv]
// Pad keeper: tri-state driver with an optional bus holder per pin
`timescale 1ns/100ps
module hppc_keeper #(
    parameter int W = 16
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic drive_in,
    input wire logic keep_en_in,
    input wire logic [W-1:0] data_in,
    output logic [W-1:0] pad_out,
    output logic [W-1:0] pad_oe_n_out,
    output logic [W-1:0] keep_out,
    output logic keep_active_out
);
    logic [W-1:0] last_r;
    logic [W-1:0] last_nxt;
    logic keep_active_nxt;

    assign last_nxt = drive_in ? data_in : last_r;
    assign keep_active_nxt = keep_en_in & ~drive_in;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            last_r <= hppc_pkg::KEEP_RST;
            pad_out <= '0;
            pad_oe_n_out <= '1;
            keep_out <= '0;
            keep_active_out <= 1'b0;
        end else begin
            last_r <= last_nxt;
            pad_out <= data_in;
            pad_oe_n_out <= {W{~drive_in}};
            keep_out <= last_nxt;
            keep_active_out <= keep_active_nxt;
        end
    end
endmodule

// [design/hppc_top.sv]
// Top: pad control of the wide address/data bus and the host byte data pins
//
// Summary of operation
// - Wide mode high: address pins are host inputs into internal memory.
// - Wide mode high: host reads and writes internal memory over data pins.
// - Data pins shared by CPU memory, I/O and host port transfers.
// - Data bus floats when idle, in device reset and during hold.
// - Data bus floats while the global output-float input is low.
// - Enabled keepers hold the last driven level on undriven data pins.
// - Data keepers off after reset; software toggles a control bit.
// - Host byte pins are host data bus, or GPIO in wide mode.
// - Host byte pins float when not outputting or output-float is low.
// - Enabled keepers hold last driven level on host pins while no host pin is driven.
// - Host keepers off after reset; separate control bit controls them.
`timescale 1ns/100ps
module hppc_top #(
    parameter int AW = 16,
    parameter int DW = 16,
    parameter int HW = 8
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    // Pad control inputs
    input wire logic device_reset_n_in,
    input wire logic hold_req_n_in,
    input wire logic out_float_n_in,
    input wire logic host_port_wide_mode_select_in,
    // Register port
    input wire logic [hppc_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // Core side of the wide bus
    input wire logic core_drive_in,
    input wire logic [DW-1:0] core_wdata_in,
    output logic [DW-1:0] core_rdata_out,
    // Host port side: byte port engine and internal memory access
    input wire logic host_byte_drive_in,
    input wire logic [HW-1:0] host_byte_wdata_in,
    output logic [HW-1:0] host_byte_rdata_out,
    input wire logic host_mem_rd_in,
    input wire logic [DW-1:0] host_mem_rdata_in,
    output logic host_mem_wr_out,
    output logic host_mem_rd_out,
    output logic [AW-1:0] host_mem_addr_out,
    output logic [DW-1:0] host_mem_wdata_out,
    input wire logic host_mem_wr_in,
    // Wide address pins (inputs in wide mode)
    input wire logic [AW-1:0] wide_address_pins_in,
    // Wide data pins
    input wire logic [DW-1:0] wide_data_pins_in,
    output logic [DW-1:0] wide_data_pins_out,
    output logic [DW-1:0] wide_data_pins_oe_n_out,
    output logic [DW-1:0] wide_data_keep_out,
    output logic wide_data_keep_en_out,
    // Host byte data pins
    input wire logic [HW-1:0] host_byte_data_pins_in,
    output logic [HW-1:0] host_byte_data_pins_out,
    output logic [HW-1:0] host_byte_data_pins_oe_n_out,
    output logic [HW-1:0] host_byte_keep_out,
    output logic host_byte_keep_en_out
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic data_bus_keeper_enable_r;
    logic host_data_keeper_enable_r;
    logic [HW-1:0] gpio_out_r;
    logic [HW-1:0] gpio_dir_r;
    logic [15:0] reg_rdata_nxt;

    wire wr_bank = reg_wr_in & (reg_addr_in == hppc_pkg::BANK_OFF);
    wire wr_gout = reg_wr_in & (reg_addr_in == hppc_pkg::GPIO_OUT_OFF);
    wire wr_gdir = reg_wr_in & (reg_addr_in == hppc_pkg::GPIO_DIR_OFF);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_bus_keeper_enable_r <=
                hppc_pkg::BANK_RST[hppc_pkg::DKEEP_BIT];
            host_data_keeper_enable_r <=
                hppc_pkg::BANK_RST[hppc_pkg::HKEEP_BIT];
            gpio_out_r <= hppc_pkg::GPIO_RST;
            gpio_dir_r <= hppc_pkg::GPIO_RST;
        end else begin
            if (!device_reset_n_in) begin
                // Keepers come up disabled out of device reset
                data_bus_keeper_enable_r <= 1'b0;
                host_data_keeper_enable_r <= 1'b0;
            end else if (wr_bank) begin
                data_bus_keeper_enable_r <= reg_wdata_in[hppc_pkg::DKEEP_BIT];
                host_data_keeper_enable_r <= reg_wdata_in[hppc_pkg::HKEEP_BIT];
            end
            if (wr_gout) begin
                gpio_out_r <= reg_wdata_in[HW-1:0];
            end
            if (wr_gdir) begin
                gpio_dir_r <= reg_wdata_in[HW-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped offsets read zero
    wire [15:0] bank_val = {14'h0000, host_data_keeper_enable_r,
                            data_bus_keeper_enable_r};
    wire [15:0] status_val = {12'h000, ~device_reset_n_in, ~hold_req_n_in,
                              ~out_float_n_in, host_port_wide_mode_select_in};

    always_comb begin
        reg_rdata_nxt = 16'h0000;
        unique case (reg_addr_in)
            hppc_pkg::BANK_OFF: reg_rdata_nxt = bank_val;
            hppc_pkg::GPIO_OUT_OFF: reg_rdata_nxt = {8'h00, gpio_out_r};
            hppc_pkg::GPIO_DIR_OFF: reg_rdata_nxt = {8'h00, gpio_dir_r};
            hppc_pkg::GPIO_IN_OFF:
                reg_rdata_nxt = {8'h00, host_byte_data_pins_in};
            hppc_pkg::STATUS_OFF: reg_rdata_nxt = status_val;
            hppc_pkg::CORE_DATA_OFF: reg_rdata_nxt = wide_data_pins_in;
            default: reg_rdata_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 16'h0000;
        end else begin
            reg_rdata_out <= reg_rd_in ? reg_rdata_nxt : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wide bus source selection
    wire wide = host_port_wide_mode_select_in;
    wire host_rd_wide = wide & host_mem_rd_in;
    // Float conditions: reset and hold for the wide bus, output-float for every driver
    wire wide_block = ~device_reset_n_in | ~hold_req_n_in;
    wire float_all = ~out_float_n_in;
    // Host reads win the pins in wide mode; core uses them otherwise
    wire wide_drive = ~wide_block & ~float_all &
                      (host_rd_wide | (core_drive_in & ~wide));
    wire [DW-1:0] wide_src = host_rd_wide ? host_mem_rdata_in
                                          : core_wdata_in;

    ////////////////////////////////////////////////////////////////////////
    // Host byte pins: host data bus, or GPIO in wide mode
    wire [HW-1:0] gpio_drv = wide ? gpio_dir_r : {HW{1'b0}};
    wire byte_drive = ~float_all & ~wide & host_byte_drive_in;
    wire [HW-1:0] byte_src = wide ? gpio_out_r : host_byte_wdata_in;
    wire [HW-1:0] byte_oe = float_all ? {HW{1'b0}}
                            : (gpio_drv | {HW{byte_drive}});

    ////////////////////////////////////////////////////////////////////////
    // Pads with keepers
    hppc_keeper #(.W(DW)) u_wide_keep (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .drive_in(wide_drive),
        .keep_en_in(data_bus_keeper_enable_r),
        .data_in(wide_src),
        .pad_out(wide_data_pins_out),
        .pad_oe_n_out(wide_data_pins_oe_n_out),
        .keep_out(wide_data_keep_out),
        .keep_active_out(wide_data_keep_en_out)
    );

    // Per-pin drive for GPIO means the holder tracks each pin separately
    logic [HW-1:0] byte_last_r;
    genvar i;
    generate
        for (i = 0; i < HW; i++) begin : g_byte
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    byte_last_r[i] <= 1'b0;
                    host_byte_data_pins_out[i] <= 1'b0;
                    host_byte_data_pins_oe_n_out[i] <= 1'b1;
                end else begin
                    if (byte_oe[i]) begin
                        byte_last_r[i] <= byte_src[i];
                    end
                    host_byte_data_pins_out[i] <= byte_src[i];
                    host_byte_data_pins_oe_n_out[i] <= ~byte_oe[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            host_byte_keep_out <= '0;
            host_byte_keep_en_out <= 1'b0;
        end else begin
            host_byte_keep_out <= (byte_last_r & ~byte_oe) |
                                  (byte_src & byte_oe);
            host_byte_keep_en_out <= host_data_keeper_enable_r &
                                     ~(|byte_oe);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host memory access and captured pin inputs
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            host_mem_wr_out <= 1'b0;
            host_mem_rd_out <= 1'b0;
            host_mem_addr_out <= '0;
            host_mem_wdata_out <= '0;
            core_rdata_out <= '0;
            host_byte_rdata_out <= '0;
        end else begin
            host_mem_wr_out <= wide & host_mem_wr_in & device_reset_n_in;
            host_mem_rd_out <= host_rd_wide & device_reset_n_in;
            host_mem_addr_out <= wide ? wide_address_pins_in : '0;
            host_mem_wdata_out <= wide_data_pins_in;
            core_rdata_out <= wide_data_pins_in;
            host_byte_rdata_out <= host_byte_data_pins_in;
        end
    end
endmodule

// [tb/hppc_host_model.sv]
// Far-side host model: drives the shared pins and resolves each pad level
`timescale 1ns/100ps
module hppc_host_model #(
    parameter int W = 16
) (
    input wire logic clk_in,
    input wire logic drive_in,
    input wire logic [W-1:0] data_in,
    input wire logic [W-1:0] dev_in,
    input wire logic [W-1:0] oe_n_in,
    input wire logic [W-1:0] keep_in,
    input wire logic keep_en_in,
    output logic [W-1:0] pins_out
);
    logic [W-1:0] last_r;
    initial last_r = '0;
    logic [W-1:0] far;
    // Undriven, unheld pins flip each cycle so a dead keeper shows up
    assign far = drive_in ? data_in : keep_en_in ? keep_in : ~last_r;
    assign pins_out = (~oe_n_in & dev_in) | (oe_n_in & far);
    always @(posedge clk_in) last_r <= pins_out;
endmodule

// [tb/hppc_top_chk.sv]
// Checker: float, drive, keeper and read timing at the top ports
`timescale 1ns/100ps
module hppc_top_chk (
    input wire logic clk_in, nrst_in, device_reset_n_in, hold_req_n_in,
    input wire logic out_float_n_in, host_port_wide_mode_select_in,
    input wire logic reg_rd_in, core_drive_in, host_mem_rd_in,
    input wire logic wide_data_keep_en_out, host_byte_keep_en_out,
    input wire logic [15:0] reg_rdata_out, core_wdata_in, host_mem_rdata_in,
    input wire logic [15:0] host_mem_addr_out, wide_address_pins_in,
    input wire logic [15:0] wide_data_pins_out, wide_data_pins_oe_n_out,
    input wire logic [7:0] host_byte_data_pins_oe_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    wire ok = out_float_n_in && device_reset_n_in && hold_req_n_in;
    wire wide = host_port_wide_mode_select_in;
    a_float_all: assert property (
        !out_float_n_in |=> &wide_data_pins_oe_n_out
        && &host_byte_data_pins_oe_n_out) else $error("pads not floated");
    a_busy_float: assert property (
        !device_reset_n_in || !hold_req_n_in |=> &wide_data_pins_oe_n_out)
        else $error("data bus driven in reset or hold");
    a_core_drive: assert property (
        ok && !wide && core_drive_in |=> wide_data_pins_oe_n_out == '0
        && wide_data_pins_out == $past(core_wdata_in))
        else $error("core data not driven");
    a_host_read: assert property (
        ok && wide && host_mem_rd_in |=> wide_data_pins_oe_n_out == '0
        && wide_data_pins_out == $past(host_mem_rdata_in))
        else $error("host read data not driven");
    a_addr_pass: assert property (
        wide |=> host_mem_addr_out == $past(wide_address_pins_in))
        else $error("host address not passed");
    a_keep_idle: assert property (
        (wide_data_keep_en_out |-> &wide_data_pins_oe_n_out) and
        (host_byte_keep_en_out |-> &host_byte_data_pins_oe_n_out))
        else $error("keeper active while driving");
    a_keep_reset: assert property (
        !device_reset_n_in |-> ##2 !wide_data_keep_en_out
        && !host_byte_keep_en_out) else $error("keeper on after reset");
    a_rd_idle: assert property (
        !reg_rd_in |=> reg_rdata_out == '0) else $error("stray read data");
endmodule
bind hppc_top hppc_top_chk i_hppc_top_chk (.clk_in, .nrst_in,
    .device_reset_n_in, .hold_req_n_in, .out_float_n_in,
    .host_port_wide_mode_select_in, .reg_rd_in, .core_drive_in,
    .host_mem_rd_in, .wide_data_keep_en_out, .host_byte_keep_en_out,
    .reg_rdata_out, .core_wdata_in, .host_mem_rdata_in, .host_mem_addr_out,
    .wide_address_pins_in, .wide_data_pins_out, .wide_data_pins_oe_n_out,
    .host_byte_data_pins_oe_n_out);

// [tb/host_port_pad_control_bench.sv]
// Bench: drive, float, keeper and register tests of the pad control
`timescale 1ns/100ps
module host_port_pad_control_bench;
    logic clk = 1'h0, nrst = 1'h0, fl = 1'h1, ho = 1'h1, dr = 1'h1;
    logic wide = 1'h0, wr = 1'h0, rd = 1'h0, cd = 1'h0, bd = 1'h0;
    logic mrd = 1'h0, mwr = 1'h0, hd = 1'h0, wke, bke, mwo;
    logic [3:0] addr = 4'h0;
    logic [7:0] bw = 8'h00, bpin, bout, boe, bkeep;
    logic [15:0] wd = '0, cw = '0, mw = '0, ha = '0, hw = '0;
    logic [15:0] rdat, wpin, wout, woe, wkeep, maddr, mwd, crd;
    logic [7:0] brd;
    int err_count = 0;
    int tests_run = 0;
    logic [22:0] rows [7] = '{{6'h3a, 16'h1234, 1'h1},
        {6'h1a, 16'h1234, 1'h0}, {6'h2a, 16'h1234, 1'h0},
        {6'h32, 16'h1234, 1'h0}, {6'h3d, 16'h8001, 1'h1},
        {6'h3e, 16'h8001, 1'h0}, {6'h38, 16'h0000, 1'h0}};
    hppc_top i_hppc_top (.clk_in(clk), .nrst_in(nrst),
        .device_reset_n_in(dr), .hold_req_n_in(ho), .out_float_n_in(fl),
        .host_port_wide_mode_select_in(wide), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdat), .core_drive_in(cd), .core_wdata_in(cw),
        .core_rdata_out(crd), .host_byte_drive_in(bd),
        .host_byte_wdata_in(bw), .host_byte_rdata_out(brd),
        .host_mem_rd_in(mrd), .host_mem_rdata_in(mw),
        .host_mem_wr_out(mwo), .host_mem_rd_out(), .host_mem_addr_out(maddr),
        .host_mem_wdata_out(mwd), .host_mem_wr_in(mwr),
        .wide_address_pins_in(ha), .wide_data_pins_in(wpin),
        .wide_data_pins_out(wout), .wide_data_pins_oe_n_out(woe),
        .wide_data_keep_out(wkeep), .wide_data_keep_en_out(wke),
        .host_byte_data_pins_in(bpin), .host_byte_data_pins_out(bout),
        .host_byte_data_pins_oe_n_out(boe), .host_byte_keep_out(bkeep),
        .host_byte_keep_en_out(bke));
    hppc_host_model i_hppc_host_model (.clk_in(clk), .drive_in(hd),
        .data_in(hw), .dev_in(wout), .oe_n_in(woe), .keep_in(wkeep),
        .keep_en_in(wke), .pins_out(wpin));
    hppc_host_model #(.W(8)) i_hppc_host_model_b (.clk_in(clk),
        .drive_in(1'h0), .data_in(8'h00), .dev_in(bout), .oe_n_in(boe),
        .keep_in(bkeep), .keep_en_in(bke), .pins_out(bpin));
    initial forever #25 clk = ~clk;
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wd <= d;
        wr <= 1'h1;
        tick(1);
        wr <= 1'h0;
        // Idle edge so a following call never re-raises wr in this step
        tick(1);
    endtask
    task automatic rreg(input logic [3:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'h1;
        tick(1);
        rd <= 1'h0;
        chk({1'h0, rdat}, {1'h0, e});
        tick(1);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        tick(1);
        rreg(hppc_pkg::BANK_OFF, 16'h0000);
        foreach (rows[i]) begin
            {fl, ho, dr, wide, cd, mrd, cw} <= rows[i][22:1];
            mw <= rows[i][16:1];
            tick(1);
            chk({1'h0, woe}, rows[i][0] ? 17'h0 : 17'hffff);
            if (rows[i][0]) chk({1'h0, wout}, {1'h0, rows[i][16:1]});
        end
        $display("row tests done");
        {fl, ho, dr, wide, cd, mrd} <= 6'h3a;
        cw <= 16'h5a3c;
        wreg(hppc_pkg::BANK_OFF, 16'h0003);
        rreg(hppc_pkg::BANK_OFF, 16'h0003);
        rreg(4'hf, 16'h0000);
        cd <= 1'h0;
        bd <= 1'h1;
        bw <= 8'hc3;
        tick(2);
        bd <= 1'h0;
        tick(3);
        chk({wke, wpin}, {1'h1, 16'h5a3c});
        chk({bke, boe, bpin}, {1'h1, 8'hff, 8'hc3});
        chk({1'h0, crd}, 17'h5a3c);
        chk({9'h000, brd}, 17'h00c3);
        wreg(hppc_pkg::BANK_OFF, 16'h0002);
        tick(2);
        chk({16'h0, wke}, 17'h0);
        $display("keeper tests done");
        wide <= 1'h1;
        hd <= 1'h1;
        hw <= 16'h7e81;
        mwr <= 1'h1;
        ha <= 16'h0f0f;
        tick(2);
        chk({mwo, mwd}, {1'h1, 16'h7e81});
        chk({1'h0, maddr}, 17'h0f0f);
        hd <= 1'h0;
        mwr <= 1'h0;
        bd <= 1'h1;
        wreg(hppc_pkg::GPIO_DIR_OFF, 16'h00ff);
        wreg(hppc_pkg::GPIO_OUT_OFF, 16'h0096);
        tick(2);
        chk({1'h0, boe, bout}, 17'h0096);
        rreg(hppc_pkg::GPIO_IN_OFF, 16'h0096);
        rreg(hppc_pkg::STATUS_OFF, 16'h0001);
        bd <= 1'h0;
        dr <= 1'h0;
        tick(2);
        dr <= 1'h1;
        rreg(hppc_pkg::BANK_OFF, 16'h0000);
        $display("wide mode tests done");
        conclude();
    end
    initial begin
        #100000;
        err_count++;
        conclude();
    end
endmodule
